// file: rtl/ppm_monitor.sv
/*
 * ppm_monitor: status monitor for four pulse output channels: position
 * counters, completion, fault, busy and activity flags, and an interrupt.
 * Assumes the pulse generator runs on ref_clk and drives its strobes
 * and levels directly; the adapter presence strap is an asynchronous pin.
 */
`timescale 1ns/10ps

// Behaviour
// - 32-bit signed position per channel, readable
// - forward pulses count up, reverse count down
// - position stays in 32-bit two's-complement range
// - counting up past maximum wraps to minimum
// - counting down past minimum wraps to maximum
// - position is lost at power-off
// - completion flag set on fault-free finish
// - abnormal-end flag set on faulted finish
// - end flags live per operation; sample promptly
// - busy flag high while pulses emitted
// - activity flag high while operation active
// - fourth channel works only with adapter present
module ppm_monitor
	import ppm_pkg::*;
(
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [ppm_pkg::PPM_ADDR_W-1:0]    paddr,
	input  wire logic [ppm_pkg::PPM_DATA_W-1:0]    pwdata,
	output logic      [ppm_pkg::PPM_DATA_W-1:0]    prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic                              adapter2_present,
	input  wire logic [ppm_pkg::PPM_CHANNELS-1:0]  pulse_out,
	input  wire logic [ppm_pkg::PPM_CHANNELS-1:0]  pulse_fwd,
	input  wire logic [ppm_pkg::PPM_CHANNELS-1:0]  pulse_run,
	input  wire logic [ppm_pkg::PPM_CHANNELS-1:0]  op_invoke,
	input  wire logic [ppm_pkg::PPM_CHANNELS-1:0]  op_done,
	input  wire logic [ppm_pkg::PPM_CHANNELS-1:0]  op_fault,
	output logic      [ppm_pkg::PPM_CHANNELS-1:0]  busy_flag,
	output logic      [ppm_pkg::PPM_CHANNELS-1:0]  active_flag,
	output logic      [ppm_pkg::PPM_CHANNELS-1:0]  done_flag,
	output logic      [ppm_pkg::PPM_CHANNELS-1:0]  fault_flag,
	output logic                                   irq
);
	import ppm_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                     adapter_meta;
	logic                     adapter_sync;
	logic [PPM_CHANNELS-1:0]  ch_en;
	logic [PPM_POS_W-1:0]     pos [PPM_CHANNELS];
	logic [PPM_CHANNELS-1:0]  pos_load;
	logic [PPM_CHANNELS-1:0]  op_start;
	logic [IRQ_W-1:0]         irq_status;
	logic [IRQ_W-1:0]         irq_mask;
	logic [IRQ_W-1:0]         irq_events;
	logic                     acc_first;
	logic                     acc_done;
	logic                     addr_ok;
	logic [PPM_DATA_W-1:0]    rd_value;
	logic [PPM_CHANNELS-1:0]  next_busy;
	logic [PPM_CHANNELS-1:0]  next_active;
	logic [PPM_CHANNELS-1:0]  next_done;
	logic [PPM_CHANNELS-1:0]  next_fault;
	logic [IRQ_W-1:0]         next_irq_status;
	logic [IRQ_W-1:0]         next_irq_mask;
	logic                     next_irq;
	logic [PPM_DATA_W-1:0]    next_prdata;
	logic                     next_pready;
	logic                     next_pslverr;

	// ----------------------------------------------------------------
	// adapter strap synchroniser
	// ----------------------------------------------------------------
	// two flops; only the second is read by logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			adapter_meta <= 1'b0;
			adapter_sync <= 1'b0;
		end else begin
			adapter_meta <= adapter2_present;
			adapter_sync <= adapter_meta;
		end
	end

	// channel enables; the fourth needs the second adapter
	assign ch_en = CH_BASE_EN | {adapter_sync, 3'b000};

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// first access cycle samples, completion edge commits
	assign acc_first = psel && penable && !pready;
	assign acc_done  = psel && penable && pready;

	// legal offsets: word aligned and inside the map
	always_comb begin
		addr_ok = 1'b0;
		case (paddr)
			OFF_POS_CH0,
			OFF_POS_CH1,
			OFF_POS_CH2,
			OFF_POS_CH3,
			OFF_FLAGS,
			OFF_IRQ_STATUS,
			OFF_IRQ_MASK: addr_ok = 1'b1;
			default:      addr_ok = 1'b0;
		endcase
	end

	// read mux
	always_comb begin
		rd_value = '0;
		case (paddr)
			OFF_POS_CH0:    rd_value = pos[0];
			OFF_POS_CH1:    rd_value = pos[1];
			OFF_POS_CH2:    rd_value = pos[2];
			OFF_POS_CH3:    rd_value = pos[3];
			OFF_FLAGS: begin
				rd_value[FLD_BUSY +: PPM_CHANNELS]   = busy_flag;
				rd_value[FLD_ACTIVE +: PPM_CHANNELS] = active_flag;
				rd_value[FLD_DONE +: PPM_CHANNELS]   = done_flag;
				rd_value[FLD_FAULT +: PPM_CHANNELS]  = fault_flag;
				rd_value[FLD_ADAPTER]                = adapter_sync;
			end
			OFF_IRQ_STATUS: rd_value[IRQ_W-1:0] = irq_status;
			OFF_IRQ_MASK:   rd_value[IRQ_W-1:0] = irq_mask;
			default:        rd_value = '0;
		endcase
	end

	// bus answer: pready one cycle after the access phase opens
	always_comb begin
		next_pready  = acc_first;
		next_pslverr = acc_first && !addr_ok;
		next_prdata  = prdata;
		if (acc_first) begin
			next_prdata = pwrite ? '0 : rd_value;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// ----------------------------------------------------------------
	// position counters
	// ----------------------------------------------------------------
	// one counter per channel; writes realign, disabled channel ignores
	genvar gi;
	generate
		for (gi = 0; gi < PPM_CHANNELS; gi++) begin : g_ch
			assign pos_load[gi] = acc_done && pwrite && ch_en[gi] &&
				paddr == OFF_POS_CH0 + 8'(gi * 4);

			ppm_pos_counter u_pos (
				.ref_clk    (ref_clk),
				.rst        (rst),
				.en         (ch_en[gi]),
				.step       (pulse_out[gi]),
				.fwd        (pulse_fwd[gi]),
				.load       (pos_load[gi]),
				.load_value (pwdata),
				.count      (pos[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// operation flags
	// ----------------------------------------------------------------
	// a new operation starts where invoke rises; the registered activity
	// flag is the previous invoke level, so no extra edge flop is needed
	assign op_start = op_invoke & ch_en & ~active_flag;

	// busy follows emission, active follows invocation, end flags per op
	always_comb begin
		next_busy   = pulse_run & ch_en;
		next_active = op_invoke & ch_en;
		next_done   = (done_flag & ~op_start) | (op_done & ch_en);
		next_fault  = (fault_flag & ~op_start) | (op_fault & ch_en);
		next_done   = next_done & ch_en;
		next_fault  = next_fault & ch_en;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy_flag   <= '0;
			active_flag <= '0;
			done_flag   <= '0;
			fault_flag  <= '0;
		end else begin
			busy_flag   <= next_busy;
			active_flag <= next_active;
			done_flag   <= next_done;
			fault_flag  <= next_fault;
		end
	end

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	// event strobes: completion in the low nibble, abnormal end above it
	assign irq_events = {op_fault & ch_en, op_done & ch_en};

	// sticky status, read clears only the bits reported; set wins
	always_comb begin
		next_irq_status = irq_status;
		next_irq_mask   = irq_mask;
		if (acc_done && !pwrite && paddr == OFF_IRQ_STATUS) begin
			next_irq_status = irq_status & ~prdata[IRQ_W-1:0];
		end
		if (acc_done && pwrite && paddr == OFF_IRQ_MASK) begin
			next_irq_mask = pwdata[IRQ_W-1:0];
		end
		next_irq_status = next_irq_status | irq_events;
		next_irq        = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_status <= '0;
			irq_mask   <= IRQ_MASK_RESET;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			irq        <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_BUSY_FOLLOWS: assert property (
		!$past(rst) |-> busy_flag == ($past(pulse_run) & $past(ch_en)))
		else $error("busy flag does not follow pulse emission");
	AST_ACTIVE_HOLDS: assert property (
		active_flag[0] && op_invoke[0] && !pulse_run[0] ##1 op_invoke[0] |=> active_flag[0])
		else $error("activity flag fell while still invoked");
	AST_ACTIVE_FALLS: assert property (
		!op_invoke[1] |=> !active_flag[1])
		else $error("activity flag stayed high after withdrawal");
	AST_DONE_SET: assert property (
		op_done[0] |=> done_flag[0] ##1 (done_flag[0] || $past(op_start[0])))
		else $error("completion flag not set");
	AST_FAULT_SET: assert property (
		(op_fault & ch_en) != 4'h0 |=> (fault_flag & $past(op_fault & ch_en)) == $past(op_fault & ch_en))
		else $error("abnormal-end flag not set");
	AST_CH3_OFF: assert property (
		!adapter_sync [*2] |-> !busy_flag[3] && !active_flag[3] && !done_flag[3] && !fault_flag[3])
		else $error("fourth channel active without adapter");
	AST_IRQ_LEVEL: assert property (
		!$past(rst) && $past(irq_events[0] && irq_mask[0]) |-> irq)
		else $error("unmasked event did not raise interrupt");
	AST_PREADY_ONE: assert property (
		acc_first |=> pready ##1 !pready)
		else $error("bus answer not a single cycle");

	// end flags drop when a new operation opens, unless set in that cycle
	AST_DONE_CLEAR: assert property (
		op_start[0] && !op_done[0] |=> !done_flag[0])
		else $error("completion flag survived a new operation");
	AST_FAULT_CLEAR: assert property (
		op_start[0] && !op_fault[0] |=> !fault_flag[0])
		else $error("abnormal-end flag survived a new operation");

	// activity follows invocation one cycle later
	AST_ACTIVE_RISE: assert property (
		op_invoke[0] |=> active_flag[0])
		else $error("activity flag missed an invocation");

	// a realigning write lands in the counter one cycle later
	AST_POS_LOAD: assert property (
		pos_load[1] |=> pos[1] == $past(pwdata))
		else $error("position write did not land");

endmodule // ppm_monitor

// file: rtl/ppm_pkg.sv
/*
 * ppm_pkg: shared constants for the pulse position status monitor.
 * Assumes an APB slave with 32-bit data and one aligned word per register.
 */
package ppm_pkg;

	// ----------------------------------------------------------------
	// structure
	// ----------------------------------------------------------------
	localparam int          PPM_CHANNELS   = 4;
	localparam int          PPM_POS_W      = 32;
	localparam int          PPM_ADDR_W     = 8;
	localparam int          PPM_DATA_W     = 32;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFF_POS_CH0    = 8'h00;
	localparam logic [7:0]  OFF_POS_CH1    = 8'h04;
	localparam logic [7:0]  OFF_POS_CH2    = 8'h08;
	localparam logic [7:0]  OFF_POS_CH3    = 8'h0C;
	localparam logic [7:0]  OFF_FLAGS      = 8'h10;
	localparam logic [7:0]  OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0]  OFF_IRQ_MASK   = 8'h18;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          FLD_BUSY       = 0;
	localparam int          FLD_ACTIVE     = 4;
	localparam int          FLD_DONE       = 8;
	localparam int          FLD_FAULT      = 12;
	localparam int          FLD_ADAPTER    = 16;
	localparam int          IRQ_FLD_DONE   = 0;
	localparam int          IRQ_FLD_FAULT  = 4;
	localparam int          IRQ_W          = 8;

	// ----------------------------------------------------------------
	// values after reset and range limits
	// ----------------------------------------------------------------
	localparam logic [31:0] POS_RESET      = 32'h0000_0000;
	localparam logic [31:0] POS_MAX        = 32'h7FFF_FFFF;
	localparam logic [31:0] POS_MIN        = 32'h8000_0000;
	localparam logic [7:0]  IRQ_MASK_RESET = 8'h00;
	localparam logic [3:0]  CH_BASE_EN     = 4'h7;

endpackage

// file: rtl/ppm_pos_counter.sv
/*
 * ppm_pos_counter: one signed 32-bit current-position counter.
 * Assumes step is a one-cycle strobe per emitted pulse on ref_clk.
 */
`timescale 1ns/10ps

module ppm_pos_counter
	import ppm_pkg::*;
(
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	input  wire logic                          en,
	input  wire logic                          step,
	input  wire logic                          fwd,
	input  wire logic                          load,
	input  wire logic [ppm_pkg::PPM_POS_W-1:0] load_value,
	output logic      [ppm_pkg::PPM_POS_W-1:0] count
);
	import ppm_pkg::*;

	logic [PPM_POS_W-1:0] next_count;

	// ----------------------------------------------------------------
	// next count: load beats a step, two's-complement wrap at both ends
	// ----------------------------------------------------------------
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = load_value;
		end else if (en && step) begin
			if (fwd) begin
				next_count = count + 32'h0000_0001;
			end else begin
				next_count = count - 32'h0000_0001;
			end
		end
	end

	// register; cleared on reset since the value is not kept
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count <= POS_RESET;
		end else begin
			count <= next_count;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_POS_INC: assert property (
		!$past(rst) && $past(en && step && fwd && !load) |-> count == $past(count) + 32'h0000_0001)
		else $error("position did not step up by one");
	AST_POS_DEC: assert property (
		!$past(rst) && $past(en && step && !fwd && !load) |-> count == $past(count) - 32'h0000_0001)
		else $error("position did not step down by one");
	AST_WRAP_UP: assert property (
		!$past(rst) && $past(en && step && fwd && !load && count == POS_MAX) |-> count == POS_MIN)
		else $error("position did not wrap from max to min");
	AST_WRAP_DN: assert property (
		!$past(rst) && $past(en && step && !fwd && !load && count == POS_MIN) |-> count == POS_MAX)
		else $error("position did not wrap from min to max");
	AST_POS_HOLD: assert property (
		!$past(rst) && $past(!load && !(en && step)) |-> $stable(count))
		else $error("position moved without a pulse");

endmodule // ppm_pos_counter

// file: sim/ppm_servo_model.sv
/*
 * ppm_servo_model: pulse-train partner that emits n pulses on one channel.
 * Assumes go is a one-cycle request sampled on ref_clk while idle.
 */
`timescale 1ns/10ps

module ppm_servo_model
	import ppm_pkg::*;
(
	input  wire logic                             ref_clk,
	input  wire logic                             go,
	input  wire logic [1:0]                       ch,
	input  wire logic                             fwd,
	input  wire logic [7:0]                       n,
	output logic      [ppm_pkg::PPM_CHANNELS-1:0] pulse_out,
	output logic      [ppm_pkg::PPM_CHANNELS-1:0] pulse_fwd,
	output logic      [ppm_pkg::PPM_CHANNELS-1:0] pulse_run,
	output logic                                  idle
);
	import ppm_pkg::*;

	logic [8:0] left = 9'h000;
	logic [1:0] sel  = 2'h0;
	logic       dir  = 1'b1;

	// half-cycle countdown, one pulse on each odd count
	always_ff @(posedge ref_clk) begin
		if (go && idle) begin
			left <= {n, 1'b0};
			sel  <= ch;
			dir  <= fwd;
		end else if (left != 9'h000) begin
			left <= left - 9'h001;
		end
	end

	// strobe and run level on the selected channel only; the other channels see the opposite direction
	always_comb begin
		idle      = (left == 9'h000);
		pulse_out = 4'h0;
		pulse_run = 4'h0;
		pulse_fwd = {4{~dir}};
		pulse_out[sel] = left[0];
		pulse_run[sel] = ~idle;
		pulse_fwd[sel] = dir;
	end
endmodule // ppm_servo_model

// file: sim/pulse_position_status_monitor_tb.sv
/*
 * pulse_position_status_monitor_tb: self-checking bench for ppm_monitor.
 * Assumes the servo model drives the pulse side and the bench is APB master.
 */
`timescale 1ns/10ps

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
	$display("[FAIL] %s exp %h got %h", nm, exp, got); end end

module pulse_position_status_monitor_tb;
	import ppm_pkg::*;

	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, e, adapter2_present = 1'b0, irq, idle;
	logic [3:0]  op_invoke = 4'h0, op_done = 4'h0, op_fault = 4'h0;
	logic [3:0]  pulse_out, pulse_fwd, pulse_run;
	logic [3:0]  busy_flag, active_flag, done_flag, fault_flag;
	logic        go = 1'b0, fwd = 1'b1;
	logic [1:0]  ch = 2'h0;
	logic [7:0]  n = 8'h00;
	int          error_cnt = 0, tests_run = 0;

	always #2.5 ref_clk = ~ref_clk;

	ppm_monitor DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adapter2_present(adapter2_present),
		.pulse_out(pulse_out), .pulse_fwd(pulse_fwd), .pulse_run(pulse_run),
		.op_invoke(op_invoke), .op_done(op_done), .op_fault(op_fault),
		.busy_flag(busy_flag), .active_flag(active_flag), .done_flag(done_flag),
		.fault_flag(fault_flag), .irq(irq));

	ppm_servo_model SRV (.ref_clk(ref_clk), .go(go), .ch(ch), .fwd(fwd), .n(n),
		.pulse_out(pulse_out), .pulse_fwd(pulse_fwd), .pulse_run(pulse_run),
		.idle(idle));

	// ----------------------------------------------------------------
	// bus and pulse tasks, entered right after a rising edge
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) error_cnt++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// let an edge pass so a following setup never overwrites the release
		@(posedge ref_clk);
	endtask

	task automatic move(input logic [1:0] c, input logic f, input logic [7:0] cnt);
		int k;
		k = 0;
		go <= 1'b1;
		ch <= c;
		fwd <= f;
		n <= cnt;
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (3) @(posedge ref_clk);
		`CHK("busy_run", (c == 2'h3 && !adapter2_present) ? 1'b0 : 1'b1, busy_flag[c])
		do begin
			@(posedge ref_clk);
			k++;
		end while (!idle && k < 600);
		if (k >= 600) error_cnt++;
		repeat (2) @(posedge ref_clk);
		`CHK("busy_stop", 1'b0, busy_flag[c])
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		apb(1'b0, OFF_POS_CH0, 32'h0);
		`CHK("pos_reset", POS_RESET, q)
		apb(1'b0, OFF_IRQ_MASK, 32'h0);
		`CHK("mask_reset", {24'h0, IRQ_MASK_RESET}, q)
	endtask

	task automatic t_count();
		move(2'h0, 1'b1, 8'h03);
		apb(1'b0, OFF_POS_CH0, 32'h0);
		`CHK("pos_fwd", 32'h0000_0003, q)
		move(2'h0, 1'b0, 8'h05);
		apb(1'b0, OFF_POS_CH0, 32'h0);
		`CHK("pos_rev_hi", 16'hFFFF, q[31:16])
		`CHK("pos_rev", 32'hFFFF_FFFE, q)
		apb(1'b1, OFF_FLAGS, 32'hFFFF_FFFF);
		apb(1'b0, OFF_FLAGS, 32'h0);
		`CHK("flags_ro", 16'h0000, q[15:0])
	endtask

	task automatic t_wrap();
		apb(1'b1, OFF_POS_CH1, POS_MAX);
		move(2'h1, 1'b1, 8'h01);
		apb(1'b0, OFF_POS_CH1, 32'h0);
		`CHK("wrap_up", POS_MIN, q)
		move(2'h1, 1'b0, 8'h01);
		apb(1'b0, OFF_POS_CH1, 32'h0);
		`CHK("wrap_down", POS_MAX, q)
	endtask

	task automatic t_ops();
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_0011);
		op_invoke <= 4'h1;
		repeat (2) @(posedge ref_clk);
		`CHK("active_on", 1'b1, active_flag[0])
		op_done <= 4'h1;
		@(posedge ref_clk);
		op_done <= 4'h0;
		repeat (2) @(posedge ref_clk);
		`CHK("done_set", 1'b1, done_flag[0])
		`CHK("irq_done", 1'b1, irq)
		`CHK("active_hold", 1'b1, active_flag[0])
		apb(1'b0, OFF_IRQ_STATUS, 32'h0);
		`CHK("stat_done", 32'h0000_0001, q)
		repeat (2) @(posedge ref_clk);
		`CHK("irq_clear", 1'b0, irq)
		op_invoke <= 4'h0;
		repeat (2) @(posedge ref_clk);
		`CHK("active_off", 1'b0, active_flag[0])
		op_invoke <= 4'h1;
		repeat (2) @(posedge ref_clk);
		`CHK("done_new_op", 1'b0, done_flag[0])
		op_fault <= 4'h1;
		@(posedge ref_clk);
		op_fault <= 4'h0;
		repeat (2) @(posedge ref_clk);
		`CHK("fault_set", 1'b1, fault_flag[0])
		`CHK("irq_fault", 1'b1, irq)
		`CHK("done_low", 1'b0, done_flag[0])
		apb(1'b0, OFF_IRQ_STATUS, 32'h0);
		`CHK("stat_fault", 32'h0000_0010, q)
		op_invoke <= 4'h0;
		@(posedge ref_clk);
	endtask

	task automatic t_adapter();
		apb(1'b1, OFF_POS_CH3, 32'h0000_0005);
		move(2'h3, 1'b1, 8'h02);
		apb(1'b0, OFF_POS_CH3, 32'h0);
		`CHK("ch3_off", 32'h0000_0000, q)
		adapter2_present <= 1'b1;
		repeat (4) @(posedge ref_clk);
		apb(1'b1, OFF_POS_CH3, 32'h0000_0005);
		move(2'h3, 1'b1, 8'h02);
		apb(1'b0, OFF_POS_CH3, 32'h0);
		`CHK("ch3_on", 32'h0000_0007, q)
		apb(1'b0, OFF_FLAGS, 32'h0);
		`CHK("adapter_bit", 1'b1, q[FLD_ADAPTER])
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped_err", 1'b1, e)
	endtask

	// reset in mid-run: positions and mask are lost
	task automatic t_rereset();
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		apb(1'b0, OFF_POS_CH1, 32'h0);
		`CHK("pos_lost", POS_RESET, q)
		apb(1'b0, OFF_IRQ_MASK, 32'h0);
		`CHK("mask_lost", {24'h0, IRQ_MASK_RESET}, q)
	endtask

	// ----------------------------------------------------------------
	// verdict
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		finish_test();
	end

	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		t_reset();
		t_count();
		t_wrap();
		t_ops();
		t_adapter();
		t_rereset();
		finish_test();
	end
endmodule // pulse_position_status_monitor_tb
